/* hdl/flash_host_defs.vh */
// Constants and timing counts for the flash bus host controller.
// Summary of operation
// R01: Device refuses array change below program lockout.
// R02: Alterations need a two-step command sequence.
// R03: Writes disabled while powerdown reset low.
// R04: Lock bits gate erase and byte write.
// R05: Read: select and enable low, strobe high.
// R06: Power-up and wake enter read array mode.
// R07: Output enable high floats the data lines.
// R08: Select high gives standby, floated data lines.
// R09: Deselect during alteration still completes it.
// R10: Powerdown reset low starts deep power-down.
// R11: Host holds powerdown reset low 100 ns.
// R12: Wake resets to read array, status 80H.
// R13: Reset low aborts a running alteration.
// R14: Host waits wake-to-write delay before commands.
// R15: Drive powerdown reset from system reset.
// R16: Identifier mode returns maker, device, lock codes.
// R17: Command write needs strobe and select low.
// R18: Command latched on first trailing strobe edge.
// R19: Host gives block or location address.
// R20: Reads work at any program supply level.
// R21: Host writes FFH to return to read array.
// R22: Done flag low while the state machine runs.
// R23: Host never drives enable and strobe together.
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH
// Clock period in picoseconds (125 MHz).
`define CLK_PERIOD_PS 8000
// Least powerdown hold in nanoseconds.
`define PD_HOLD_NS 100
// Hold in cycles, rounded up.
`define PD_HOLD_CYC ((`PD_HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Wake-to-output delay in nanoseconds.
`define WAKE_OUT_NS 100
`define WAKE_OUT_CYC ((`WAKE_OUT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Wake-to-write delay in nanoseconds.
`define WAKE_WR_NS 1000
`define WAKE_WR_CYC ((`WAKE_WR_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Timer count loaded for each bus phase (setup, strobe low, hold); each phase lasts two cycles more.
`define PHASE_CYC 4
// Read array command code.
`define CMD_READ_ARRAY 8'hff
// Status value the device holds after wake.
`define STATUS_WAKE 8'h80
`endif

/* hdl/cycle_timer.v */
// Down-counting delay timer used for bus phases and wake delays.
`timescale 1ns/1ps
module cycle_timer (
    input wire clock_i,
    input wire rst_i,
    input wire load_i,
    input wire [7:0] count_i,
    output wire done_o
);
    // Remaining cycles.
    reg [7:0] count_r;
    // Load takes a new count, otherwise count down to zero.
    always @(posedge clock_i) begin
        if (rst_i) begin
            count_r <= 8'h00;
        end else if (load_i) begin
            count_r <= count_i;
        end else if (count_r != 8'h00) begin
            count_r <= count_r - 8'h01;
        end
    end
    // Done when the count has run out and no new load is pending.
    assign done_o = (count_r == 8'h00) && !load_i;
endmodule

/* hdl/flash_host.v */
// Host controller that drives the parallel flash bus pins.
`timescale 1ns/1ps
`include "flash_host_defs.vh"
module flash_host (
    input wire clock_i,
    input wire rst_i,
    input wire req_valid_i,
    input wire req_write_i,
    input wire [20:0] req_addr_i,
    input wire [7:0] req_data_i,
    output wire req_ready_o,
    output reg rsp_valid_o,
    output reg [7:0] rsp_data_o,
    input wire pd_req_i,
    output reg awake_o,
    output reg [20:0] addr_o,
    output reg chip_sel_n_o,
    output reg out_en_n_o,
    output reg write_en_n_o,
    output reg powerdown_reset_n_o,
    input wire [7:0] data_lines_i,
    output reg [7:0] data_lines_o,
    output reg data_lines_oe_o,
    input wire done_flag_out_i,
    output reg done_flag_o
);
    // Bus sequencer states.
    localparam ST_RESET = 4'd0;
    localparam ST_WAKE = 4'd1;
    localparam ST_IDLE = 4'd2;
    localparam ST_RD_SETUP = 4'd3;
    localparam ST_RD_STROBE = 4'd4;
    localparam ST_WR_SETUP = 4'd5;
    localparam ST_WR_STROBE = 4'd6;
    localparam ST_WR_HOLD = 4'd7;
    localparam ST_PD = 4'd8;
    localparam ST_RD_HOLD = 4'd9;
    // Current state.
    reg [3:0] state_r;
    // Next state.
    reg [3:0] state_nxt;
    // Timing counts kept 32 bits wide so each load below takes the low byte on purpose.
    localparam [31:0] PD_HOLD_W = `PD_HOLD_CYC;
    // Wake-to-output wait in cycles.
    localparam [31:0] WAKE_OUT_W = `WAKE_OUT_CYC;
    // Wake-to-write wait in cycles.
    localparam [31:0] WAKE_WR_W = `WAKE_WR_CYC;
    // Timer count for each bus phase; the phase lasts two cycles more.
    localparam [31:0] PHASE_W = `PHASE_CYC;
    // Timer load strobe and count.
    reg load_r;
    reg [7:0] load_cnt_r;
    // Counts down the wake-to-write time from pin release; writes wait until it reaches zero.
    reg [7:0] wr_wait_r;
    // Timer expiry.
    wire timer_done;
    // Delay timer for phases and wake intervals.
    cycle_timer u_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .load_i(load_r),
        .count_i(load_cnt_r),
        .done_o(timer_done)
    );
    // Ready accepts a request only in idle; writes wait out the wake-to-write time.
    assign req_ready_o = (state_r == ST_IDLE) && !pd_req_i && (!req_write_i || wr_wait_r == 8'h00); // R14
    // Next state selection.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            // Reset holds the pin low at least the minimum time.
            ST_RESET: begin
                if (timer_done) begin
                    state_nxt = ST_WAKE; // R11
                end
            end
            // Wait the wake-to-output delay before any read.
            ST_WAKE: begin
                if (timer_done) begin
                    state_nxt = ST_IDLE; // R12
                end
            end
            // Idle starts a power-down, a read or a write.
            ST_IDLE: begin
                if (pd_req_i) begin
                    state_nxt = ST_PD; // R10
                end else if (req_valid_i && req_ready_o) begin
                    state_nxt = req_write_i ? ST_WR_SETUP : ST_RD_SETUP; // R02
                end
            end
            ST_RD_SETUP: begin
                if (timer_done) begin
                    state_nxt = ST_RD_STROBE;
                end
            end
            ST_RD_STROBE: begin
                if (timer_done) begin
                    state_nxt = ST_RD_HOLD;
                end
            end
            ST_RD_HOLD: begin
                if (timer_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WR_SETUP: begin
                if (timer_done) begin
                    state_nxt = ST_WR_STROBE;
                end
            end
            ST_WR_STROBE: begin
                if (timer_done) begin
                    state_nxt = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                if (timer_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            // Power-down lasts at least the minimum hold, then until released.
            ST_PD: begin
                if (timer_done && !pd_req_i) begin
                    state_nxt = ST_WAKE; // R11
                end
            end
            default: begin
                state_nxt = ST_RESET;
            end
        endcase
    end
    // State register, timer loads and bus pin drive.
    always @(posedge clock_i) begin
        if (rst_i) begin
            // System reset also drives the flash reset pin low.
            state_r <= ST_RESET; // R15
            load_r <= 1'b1;
            load_cnt_r <= PD_HOLD_W[7:0];
            wr_wait_r <= 8'h00;
            addr_o <= 21'h000000;
            chip_sel_n_o <= 1'b1;
            out_en_n_o <= 1'b1;
            write_en_n_o <= 1'b1;
            powerdown_reset_n_o <= 1'b0;
            data_lines_o <= 8'h00;
            data_lines_oe_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
            awake_o <= 1'b0;
            done_flag_o <= 1'b1;
        end else begin
            state_r <= state_nxt;
            load_r <= 1'b0;
            rsp_valid_o <= 1'b0;
            done_flag_o <= done_flag_out_i; // R22
            if (wr_wait_r != 8'h00) begin
                wr_wait_r <= wr_wait_r - 8'h01;
            end
            if (state_nxt != state_r) begin
                load_r <= 1'b1;
                load_cnt_r <= PHASE_W[7:0];
                case (state_nxt)
                    // Pin low begins power-down and aborts any alteration.
                    ST_PD: begin
                        load_cnt_r <= PD_HOLD_W[7:0]; // R13
                        powerdown_reset_n_o <= 1'b0; // R10
                        chip_sel_n_o <= 1'b1;
                        awake_o <= 1'b0;
                    end
                    // Release the pin; device returns to read array mode.
                    ST_WAKE: begin
                        load_cnt_r <= WAKE_OUT_W[7:0]; // R06
                        powerdown_reset_n_o <= 1'b1;
                        wr_wait_r <= WAKE_WR_W[7:0]; // R14
                    end
                    ST_IDLE: begin
                        awake_o <= 1'b1;
                        chip_sel_n_o <= 1'b1;
                        out_en_n_o <= 1'b1;
                        write_en_n_o <= 1'b1;
                        data_lines_oe_o <= 1'b0;
                    end
                    // Address set up, select asserted, strobes high.
                    ST_RD_SETUP: begin
                        addr_o <= req_addr_i; // R19
                        chip_sel_n_o <= 1'b0;
                    end
                    // Output enable low with write strobe held high.
                    ST_RD_STROBE: begin
                        out_en_n_o <= 1'b0; // R05
                    end
                    // Sample data, then release enable before anything else.
                    ST_RD_HOLD: begin
                        rsp_data_o <= data_lines_i; // R20
                        rsp_valid_o <= 1'b1;
                        out_en_n_o <= 1'b1; // R07
                    end
                    // Drive address and data with output enable high.
                    ST_WR_SETUP: begin
                        addr_o <= req_addr_i; // R19
                        data_lines_o <= req_data_i; // R21
                        data_lines_oe_o <= 1'b1;
                        out_en_n_o <= 1'b1; // R23
                        chip_sel_n_o <= 1'b0;
                    end
                    // Write strobe low with select low opens the command cycle.
                    ST_WR_STROBE: begin
                        write_en_n_o <= 1'b0; // R17
                    end
                    // Strobe rises first; address and data stay stable past it.
                    ST_WR_HOLD: begin
                        write_en_n_o <= 1'b1; // R18
                    end
                    default: begin
                        load_cnt_r <= PHASE_W[7:0];
                    end
                endcase
            end
        end
    end
endmodule

/* testbench/flash_host_assertions.sv */
// Assertions on the pins of the flash host controller.
`timescale 1ns/1ps
module flash_host_assertions (
    input logic clock_i,
    input logic rst_i,
    input logic pd_req_i,
    input logic req_ready_o,
    input logic rsp_valid_o,
    input logic awake_o,
    input logic [20:0] addr_o,
    input logic chip_sel_n_o,
    input logic out_en_n_o,
    input logic write_en_n_o,
    input logic powerdown_reset_n_o,
    input logic [7:0] data_lines_o,
    input logic data_lines_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    reg [7:0] lo_r = 8'h00; // Cycles the power-down pin has been low.
    reg [7:0] hi_r = 8'h00; // Cycles since the power-down pin rose.
    // Saturating counters for the hold and write-wait checks.
    always @(posedge clock_i) begin
        lo_r <= (rst_i || powerdown_reset_n_o) ? 8'h00 : lo_r + {7'h00, lo_r != 8'hff};
        hi_r <= !powerdown_reset_n_o ? 8'h00 : hi_r + {7'h00, hi_r != 8'hff};
    end
    // Strobe low with select, data driven, address and data held.
    sequence s_wr;
        (!write_en_n_o && !chip_sel_n_o && data_lines_oe_o && $stable(addr_o) && $stable(data_lines_o))[*6];
    endsequence
    // Output enable low with select, lines released, address held.
    sequence s_rd;
        (!out_en_n_o && !chip_sel_n_o && !data_lines_oe_o && $stable(addr_o))[*6];
    endsequence
    AST_PD_HOLD: assert property ($rose(powerdown_reset_n_o) |-> lo_r >= 8'd13) else $error("short pd");
    AST_WAKE_WR: assert property ($fell(write_en_n_o) |-> hi_r >= 8'd125) else $error("early write");
    AST_WR_CYC: assert property ($fell(write_en_n_o) |-> s_wr ##1 (write_en_n_o && !chip_sel_n_o && data_lines_oe_o))
        else $error("bad write");
    AST_RD_CYC: assert property ($fell(out_en_n_o) |-> s_rd ##1 (rsp_valid_o && out_en_n_o))
        else $error("bad read");
    AST_NO_BOTH: assert property (!out_en_n_o |-> write_en_n_o) else $error("oe and we low");
    AST_PD_REFUSE: assert property ((pd_req_i || !awake_o) |-> !req_ready_o) else $error("ready in pd");
    AST_PD_ENTER: assert property ($rose(pd_req_i) && awake_o |-> ##[1:20] !powerdown_reset_n_o) else $error("no pd");
    AST_PD_QUIET: assert property (!powerdown_reset_n_o |-> chip_sel_n_o && !data_lines_oe_o) else $error("busy pd");
endmodule
bind flash_host flash_host_assertions i_chk (.*);

/* testbench/flash_dev_model.sv */
// Behavioural model of the byte-wide flash device.
`timescale 1ns/1ps
module flash_dev_model #(parameter [7:0] MAKER = 8'h5c, parameter [7:0] DEVICE = 8'ha3) ( // Codes are arbitrary.
    input wire [20:0] addr_i,
    input wire cs_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire powerdown_reset_n_i,
    input wire [7:0] data_lines_i,
    output wire [7:0] data_lines_o,
    output wire done_flag_out_o
);
    reg [7:0] mem [0:255]; // Low address bits index a small erased array.
    reg [1:0] mode_r = 2'd0;
    reg setup_r = 1'b0; // Byte write setup seen.
    reg busy_r = 1'b0; // Alteration running.
    reg woke_r = 1'b1; // Wake delay over.
    reg [7:0] last_r = 8'h00; // Last driven byte.
    integer i;
    wire prog_ok = 1'b1;
    wire pd = powerdown_reset_n_i;
    wire wr = !cs_n_i && !we_n_i && pd;
    wire drv = !cs_n_i && !oe_n_i && we_n_i && pd && woke_r;
    wire [1:0] sel = addr_i[1:0];
    wire [7:0] id = sel == 2'd0 ? MAKER : sel == 2'd1 ? DEVICE : {7'h00, sel == 2'd2 && addr_i[20:16] == 5'h01};
    wire [7:0] rd = mode_r == 2'd1 ? id : mode_r == 2'd2 ? {!busy_r, 7'h00} : mem[addr_i[7:0]];
    assign data_lines_o = drv ? rd : ~last_r; // Released lines show the inverse of the last byte seen changing while driven.
    assign done_flag_out_o = !busy_r;
    initial for (i = 0; i < 256; i = i + 1) mem[i] = 8'hff;
    always @(data_lines_o) if (drv) last_r = data_lines_o;
    // A command is taken when the first of strobe or select rises.
    always @(negedge wr) if (pd) begin
        if (setup_r) begin
            mode_r = 2'd2;
            busy_r = prog_ok && addr_i[20:16] != 5'h01;
            if (busy_r) mem[addr_i[7:0]] = mem[addr_i[7:0]] & data_lines_i;
        end else if (!busy_r) begin
            if (data_lines_i == 8'hff) mode_r = 2'd0;
            if (data_lines_i == 8'h90) mode_r = 2'd1;
            if (data_lines_i == 8'h70) mode_r = 2'd2;
        end
        setup_r = !setup_r && !busy_r && (data_lines_i == 8'h40 || data_lines_i == 8'h10);
    end
    always @(posedge busy_r) busy_r = #2000 1'b0;
    // Power-down aborts work and returns to array reads.
    always @(negedge pd) begin
        busy_r = 1'b0;
        setup_r = 1'b0;
        mode_r = 2'd0;
        woke_r = 1'b0;
    end
    always @(posedge pd) woke_r = #100 1'b1;
endmodule

/* testbench/flash_bus_ops_and_protection_bench.sv */
// Self-checking bench: flash host controller against the device model.
`timescale 1ns/1ps
module flash_bus_ops_and_protection_bench;
    reg clock_i = 1'b0;
    reg rst_i = 1'b1;
    reg req_valid_i = 1'b0;
    reg req_write_i = 1'b0;
    reg [20:0] req_addr_i = 21'h000000;
    reg [7:0] req_data_i = 8'h00;
    reg pd_req_i = 1'b0;
    reg [7:0] q; // Byte returned by the last read.
    integer mismatches = 0;
    integer num_checks = 0;
    integer cycles = 0;
    wire req_ready_o, rsp_valid_o, awake_o, chip_sel_n_o, out_en_n_o, write_en_n_o, powerdown_reset_n_o;
    wire data_lines_oe_o, done_flag_out_i, done_flag_o;
    wire [7:0] rsp_data_o, data_lines_o, dev_d;
    wire [20:0] addr_o;
    wire [7:0] data_lines_i = data_lines_oe_o ? data_lines_o : dev_d; // Resolved data lines.
    flash_host i_dut (.*);
    flash_dev_model i_dev (.addr_i(addr_o), .cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o), .we_n_i(write_en_n_o),
        .powerdown_reset_n_i(powerdown_reset_n_o), .data_lines_i(data_lines_i), .data_lines_o(dev_d),
        .done_flag_out_o(done_flag_out_i));
    initial forever #4 clock_i = ~clock_i;
    task check(input [7:0] seen, input [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One host request, held until taken; a read leaves its byte in q.
    task op(input wr, input [20:0] a, input [7:0] d);
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_write_i <= wr;
        req_addr_i <= a;
        req_data_i <= d;
        @(negedge clock_i);
        while (req_ready_o !== 1'b1) @(negedge clock_i);
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        while (!wr && rsp_valid_o !== 1'b1) @(negedge clock_i);
        q = rsp_data_o;
    endtask
    task rd(input [20:0] a); op(1'h0, a, 8'h00); endtask
    // Two-step write, a stray write and a write to the locked block.
    task t_write;
        rd(21'h20);
        check(q, 8'hff);
        op(1'h1, 21'h20, 8'h40);
        op(1'h1, 21'h20, 8'h5a);
        rd(21'h20);
        check({q[7], done_flag_o}, 8'h00);
        while (q[7] !== 1'b1) rd(21'h20);
        op(1'h1, 21'h30, 8'h5a);
        op(1'h1, 21'h10004, 8'h40);
        op(1'h1, 21'h10004, 8'h00);
        op(1'h1, 21'h0, 8'hff);
        rd(21'h20);
        check(q, 8'h5a);
        rd(21'h30);
        check(q, 8'hff);
        rd(21'h10004);
        check(q, 8'hff);
        $display("write test done");
    endtask
    // Identifier reads of block one, which is locked.
    task t_ident;
        integer n;
        op(1'h1, 21'h0, 8'h90);
        for (n = 0; n < 4; n = n + 1) begin
            rd(21'h10000 + n[20:0]);
            check(q, n == 0 ? 8'h5c : n == 1 ? 8'ha3 : {7'h00, n == 2});
        end
        $display("ident test done");
    endtask
    // Power-down in mid-write, then wake.
    task t_powerdown;
        op(1'h1, 21'h40, 8'h10);
        op(1'h1, 21'h40, 8'h0f);
        rd(21'h40);
        check(q, 8'h00);
        repeat (8) @(posedge clock_i);
        pd_req_i <= 1'b1;
        @(negedge clock_i);
        check({7'h00, req_ready_o}, 8'h00);
        repeat (30) @(negedge clock_i);
        check({powerdown_reset_n_o, done_flag_o}, 8'h01);
        check({7'h00, awake_o}, 8'h00);
        @(posedge clock_i);
        pd_req_i <= 1'b0;
        rd(21'h20);
        check(q, 8'h5a);
        check({7'h00, awake_o}, 8'h01);
        op(1'h1, 21'h0, 8'h70);
        rd(21'h0);
        check(q, 8'h80);
        $display("power-down test done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        t_write;
        t_ident;
        t_powerdown;
        end_of_test;
    end
endmodule
